/* File: logic/ebpi_pkg.sv */
/*
 * Package for the external bus pin interface: pin map, enumerations and
 * pin-group structs. Assumes a single 10 MHz core clock.
 */
package ebpi_pkg;

    // Bit positions within the port-mode / port-data vector of shared pins
    localparam int PIN_RDY     = 0;
    localparam int PIN_GRANT   = 1;
    localparam int PIN_REQ     = 2;
    localparam int PIN_WRLO    = 3;
    localparam int PIN_CS1     = 4;
    localparam int PIN_CS2     = 5;
    localparam int PIN_CS3     = 6;
    localparam int PIN_CS4     = 7;
    localparam int PIN_CS5     = 8;
    localparam int PIN_CLK     = 9;
    localparam int PIN_DRAM_ROW_STROBE_BANK0    = 10;
    localparam int PIN_CAS0L   = 11;
    localparam int PIN_CAS0H   = 12;
    localparam int PIN_DW0     = 13;
    localparam int PIN_DRAM_ROW_STROBE_BANK1    = 14;
    localparam int PIN_CAS1L   = 15;
    localparam int PIN_CAS1H   = 16;
    localparam int PIN_DW1     = 17;
    localparam int NUM_PINS    = 18;

    localparam int NUM_AREAS   = 6;
    localparam int DRAM_AREA0  = 4;
    localparam int DRAM_AREA1  = 5;

    localparam logic [NUM_PINS-1:0] PINS_ALL_ONE = {NUM_PINS{1'b1}};
    localparam logic [5:0]          CS_IDLE      = 6'h3F;

    typedef enum logic {
        EBPI_WIDTH_8,
        EBPI_WIDTH_16
    } ebpi_width_type;

    typedef enum {
        EBPI_IDLE,
        EBPI_ACCESS,
        EBPI_RELEASED
    } ebpi_state_type;

    // Internal access request from the core side
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [1:0]  lanes;    // [1] upper byte D15..D08, [0] lower byte D07..D00
        logic [2:0]  area;
    } ebpi_req_type;

    // Active-low strobe pins of the bus
    typedef struct packed {
        logic       read_n;
        logic       write_upper_n;
        logic       write_lower_n;
        logic [5:0] area_sel_n;
    } ebpi_strobe_type;

    // Active-low DRAM pins of one bank
    typedef struct packed {
        logic row_n;
        logic col_low_n;
        logic col_high_n;
        logic we_n;
    } ebpi_dram_type;

endpackage : ebpi_pkg

/* File: logic/ebpi_top.sv */
/*
 * External bus pin interface: ready wait, bus release handshake, strobes,
 * area selects, bus clock, DRAM strobes, DMA end-of-transfer, and port
 * fallback for every shared pin. Assumes all inputs synchronous to mclk.
 */
// Notes on behaviour
// - Ready low stretches the running bus cycle until ready goes high again.
// - Acknowledge output asserted once the device has let go of the bus.
// - 16-bit bus: upper strobe for upper lane, lower strobe for lower lane.
// - 8-bit bus: only the upper strobe writes; lower strobe pin becomes a port.
// - Lower write strobe floats while reset is active.
// - Separate read strobe drives external reads.
// - Six active-low area selects; select 0 dedicated, others may be ports.
// - Bus clock output at bus rate unless disabled, then pin is a port.
// - Each DRAM bank has row, low and high column strobes and write enable.
// - Channel 1 end-of-transfer on select 3 pin only when enabled.
// - Channel 2 end-of-transfer on bank 1 row pin only when enabled.
`timescale 1ns/1ps

module ebpi_top
    import ebpi_pkg::*;
#(
    parameter int CLK_DIV = 2
) (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  nrst,
    // Configuration
    input  wire ebpi_width_type        bus_width,
    input  wire logic [NUM_PINS-1:0]   port_mode,
    input  wire logic                  dma_eot_enable,
    // Port data for pins in port mode
    input  wire logic [NUM_PINS-1:0]   port_out,
    output logic      [NUM_PINS-1:0]   port_in_q,
    // Core access request
    input  wire ebpi_req_type          core_req,
    output logic                       core_done_q,
    input  wire logic                  dma_eot_ch1,
    input  wire logic                  dma_eot_ch2,
    // Bus pins
    input  wire logic                  ready_in,
    input  wire logic                  bus_release_req_in,
    output logic                       bus_release_ack_out,
    output ebpi_strobe_type            strobe_q,
    output logic                       strobe_oe_q,
    output logic                       write_strobe_lower_oe_q,
    output logic                       bus_clk_q,
    output ebpi_dram_type              dram_bank0_q,
    output ebpi_dram_type              dram_bank1_q,
    output logic                       addr_data_oe_q
);

    // The divider toggles on half periods, so only even ratios can be served
    if (CLK_DIV < 2 || CLK_DIV % 2 != 0) begin : g_bad_div
        $error("CLK_DIV must be an even number of at least 2");
    end

    ebpi_state_type state_q, state_d;
    ebpi_req_type   req_q;
    logic [$clog2(CLK_DIV+1)-1:0] div_q;
    logic           clk_int_q;
    logic           grant_q;
    logic           in_reset_q;

    // Next-state decode
    wire logic req_pending = bus_release_req_in && !port_mode[PIN_REQ];
    wire logic ready_ok    = port_mode[PIN_RDY] || ready_in;
    wire logic is_dram     = (req_q.area == 3'(DRAM_AREA0)) ||
                             (req_q.area == 3'(DRAM_AREA1));

    always_comb begin
        state_d = state_q;
        case (state_q)
            EBPI_IDLE: begin
                if (req_pending) begin
                    state_d = EBPI_RELEASED;
                end else if (core_req.valid) begin
                    state_d = EBPI_ACCESS;
                end
            end
            EBPI_ACCESS: begin
                if (ready_ok) begin
                    state_d = EBPI_IDLE;
                end
            end
            EBPI_RELEASED: begin
                if (!req_pending) begin
                    state_d = EBPI_IDLE;
                end
            end
            default: state_d = EBPI_IDLE;
        endcase
    end

    // Strobe decode for the cycle in progress
    wire logic active   = (state_q == EBPI_ACCESS);
    wire logic wr_act   = active && req_q.write;
    wire logic wide     = (bus_width == EBPI_WIDTH_16);
    wire logic wr_up    = wr_act && (wide ? req_q.lanes[1] : 1'b1);
    wire logic wr_lo    = wr_act && wide && req_q.lanes[0];
    wire logic rd_act   = active && !req_q.write;
    wire logic [5:0] sel_n = active ? ~(6'h01 << req_q.area) : CS_IDLE;
    wire logic dram_row_strobe_bank0     = active && (req_q.area == 3'(DRAM_AREA0));
    wire logic dram_row_strobe_bank1     = active && (req_q.area == 3'(DRAM_AREA1));
    wire logic cas_l    = active && is_dram && (wide ? req_q.lanes[0] : 1'b1);
    wire logic cas_h    = active && is_dram && req_q.lanes[1];

    // Pin multiplexing between bus function, DMA and port
    wire logic lo_is_port = port_mode[PIN_WRLO] || !wide;
    wire logic [5:0] cs_pin = {
        port_mode[PIN_CS5] ? port_out[PIN_CS5] : sel_n[5],
        port_mode[PIN_CS4] ? port_out[PIN_CS4] : sel_n[4],
        dma_eot_enable ? !dma_eot_ch1 :
            (port_mode[PIN_CS3] ? port_out[PIN_CS3] : sel_n[3]),
        port_mode[PIN_CS2] ? port_out[PIN_CS2] : sel_n[2],
        port_mode[PIN_CS1] ? port_out[PIN_CS1] : sel_n[1],
        sel_n[0]
    };
    wire logic dram_row_strobe_bank1_pin = dma_eot_enable ? !dma_eot_ch2 :
                          (port_mode[PIN_DRAM_ROW_STROBE_BANK1] ? port_out[PIN_DRAM_ROW_STROBE_BANK1] : !dram_row_strobe_bank1);
    wire logic clk_pin  = port_mode[PIN_CLK] ? port_out[PIN_CLK] : clk_int_q;
    wire logic ack_pin  = port_mode[PIN_GRANT] ? port_out[PIN_GRANT] : grant_q;
    wire ebpi_dram_type bank0 = '{
        row_n:      port_mode[PIN_DRAM_ROW_STROBE_BANK0]  ? port_out[PIN_DRAM_ROW_STROBE_BANK0]  : !dram_row_strobe_bank0,
        col_low_n:  port_mode[PIN_CAS0L] ? port_out[PIN_CAS0L] : !(cas_l && dram_row_strobe_bank0),
        col_high_n: port_mode[PIN_CAS0H] ? port_out[PIN_CAS0H] : !(cas_h && dram_row_strobe_bank0),
        we_n:       port_mode[PIN_DW0]   ? port_out[PIN_DW0]   : !(wr_act && dram_row_strobe_bank0)
    };
    wire ebpi_dram_type bank1 = '{
        row_n:      dram_row_strobe_bank1_pin,
        col_low_n:  port_mode[PIN_CAS1L] ? port_out[PIN_CAS1L] : !(cas_l && dram_row_strobe_bank1),
        col_high_n: port_mode[PIN_CAS1H] ? port_out[PIN_CAS1H] : !(cas_h && dram_row_strobe_bank1),
        we_n:       port_mode[PIN_DW1]   ? port_out[PIN_DW1]   : !(wr_act && dram_row_strobe_bank1)
    };
    wire ebpi_strobe_type strobes = '{
        read_n:        !rd_act,
        write_upper_n: !wr_up,
        write_lower_n: lo_is_port ? port_out[PIN_WRLO] : !wr_lo,
        area_sel_n:    cs_pin
    };
    wire logic released = (state_d == EBPI_RELEASED);
    // Stay off the bus until the registered grant has been withdrawn
    wire logic drive_ok = !released && !grant_q;
    wire logic div_wrap = (div_q == ($clog2(CLK_DIV+1))'(CLK_DIV/2 - 1));

    // Sequencing
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_q <= EBPI_IDLE;
            req_q   <= '0;
        end else begin
            state_q <= state_d;
            if (state_q == EBPI_IDLE && !req_pending && core_req.valid) begin
                req_q <= core_req;
            end
        end
    end

    // Bus clock divider
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            div_q     <= '0;
            clk_int_q <= 1'b0;
        end else begin
            div_q     <= div_wrap ? '0 : div_q + 1'b1;
            clk_int_q <= div_wrap ? !clk_int_q : clk_int_q;
        end
    end

    // Registered pin outputs
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            in_reset_q              <= 1'b1;
            grant_q                 <= 1'b0;
            core_done_q             <= 1'b0;
            port_in_q               <= '0;
            bus_release_ack_out     <= 1'b0;
            strobe_q                <= '1;
            strobe_oe_q             <= 1'b0;
            write_strobe_lower_oe_q <= 1'b0;
            bus_clk_q               <= 1'b0;
            dram_bank0_q            <= '1;
            dram_bank1_q            <= '1;
            addr_data_oe_q          <= 1'b0;
        end else begin
            in_reset_q              <= 1'b0;
            grant_q                 <= released;
            core_done_q             <= active && ready_ok;
            port_in_q               <= {PINS_ALL_ONE[NUM_PINS-1:3], bus_release_req_in,
                                        1'b1, ready_in} & port_mode;
            bus_release_ack_out     <= ack_pin;
            strobe_q                <= strobes;
            strobe_oe_q             <= drive_ok;
            write_strobe_lower_oe_q <= drive_ok && !in_reset_q;
            bus_clk_q               <= clk_pin;
            dram_bank0_q            <= bank0;
            dram_bank1_q            <= bank1;
            addr_data_oe_q          <= drive_ok && active;
        end
    end

endmodule : ebpi_top

/* File: sim/ebpi_checker.sv */
/* Pin relations of ebpi_top.
   Assumes a bind onto ebpi_top, all inputs synchronous to mclk. */
`timescale 1ns/1ps
module ebpi_checker
    import ebpi_pkg::*;
#(
    parameter int CLK_DIV = 2
) (
    // Clock, reset, configuration
    input wire logic                mclk,
    input wire logic                nrst,
    input wire ebpi_width_type      bus_width,
    input wire logic [NUM_PINS-1:0] port_mode,
    input wire logic [NUM_PINS-1:0] port_out,
    input wire logic                dma_eot_enable,
    input wire logic                dma_eot_ch1,
    input wire logic                dma_eot_ch2,
    // Bus pins
    input wire logic                core_done_q,
    input wire logic                ready_in,
    input wire logic                bus_release_req_in,
    input wire logic                bus_release_ack_out,
    input wire ebpi_strobe_type     strobe_q,
    input wire logic                strobe_oe_q,
    input wire logic                write_strobe_lower_oe_q,
    input wire logic                bus_clk_q,
    input wire ebpi_dram_type       dram_bank1_q,
    input wire logic                addr_data_oe_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_req_gone;
        !bus_release_req_in [*4];
    endsequence
    a_done_after_ready: assert property (core_done_q
        |-> $past(ready_in || port_mode[PIN_RDY]))
        else $error("done without ready");
    a_grant_held: assert property (bus_release_ack_out && bus_release_req_in |=> bus_release_ack_out)
        else $error("grant dropped early");
    a_grant_ends: assert property (s_req_gone |-> !bus_release_ack_out)
        else $error("grant kept after request");
    a_grant_floats: assert property (bus_release_ack_out |-> !strobe_oe_q && !addr_data_oe_q)
        else $error("bus driven while granted");
    a_lower_hiz_rst: assert property (disable iff (1'b0) !nrst |=> !write_strobe_lower_oe_q)
        else $error("lower strobe driven in reset");
    a_one_area: assert property (port_mode == '0 && $past(port_mode) == '0 && !dma_eot_enable
        && !$past(dma_eot_enable) |-> $onehot0(~strobe_q.area_sel_n))
        else $error("several areas selected");
    a_bus_clk_runs: assert property (CLK_DIV == 2 && !port_mode[PIN_CLK]
        && !$past(port_mode[PIN_CLK]) && !$past(port_mode[PIN_CLK], 2)
        && $past(nrst) && $past(nrst, 2) |-> bus_clk_q != $past(bus_clk_q))
        else $error("bus clock stalled");
    a_eot_ch1_pin: assert property (dma_eot_enable && $past(dma_eot_enable) && $past(nrst)
        && $stable(dma_eot_ch1) |-> strobe_q.area_sel_n[3] == !dma_eot_ch1)
        else $error("ch1 eot pin wrong");
    a_eot_ch2_pin: assert property (dma_eot_enable && $past(dma_eot_enable) && $past(nrst)
        && $stable(dma_eot_ch2) |-> dram_bank1_q.row_n == !dma_eot_ch2)
        else $error("ch2 eot pin wrong");
    a_port_cs1: assert property (port_mode[PIN_CS1] && $past(port_mode[PIN_CS1]) && $past(nrst)
        && $stable(port_out[PIN_CS1]) |-> strobe_q.area_sel_n[1] == port_out[PIN_CS1])
        else $error("select 1 port value wrong");
endmodule : ebpi_checker

bind ebpi_top ebpi_checker #(.CLK_DIV(CLK_DIV)) chk (.mclk(mclk), .nrst(nrst),
    .bus_width(bus_width), .port_mode(port_mode), .port_out(port_out),
    .dma_eot_enable(dma_eot_enable), .dma_eot_ch1(dma_eot_ch1), .dma_eot_ch2(dma_eot_ch2),
    .core_done_q(core_done_q), .ready_in(ready_in), .bus_release_req_in(bus_release_req_in),
    .bus_release_ack_out(bus_release_ack_out), .strobe_q(strobe_q), .strobe_oe_q(strobe_oe_q),
    .write_strobe_lower_oe_q(write_strobe_lower_oe_q), .bus_clk_q(bus_clk_q),
    .dram_bank1_q(dram_bank1_q), .addr_data_oe_q(addr_data_oe_q));

/* File: sim/ebpi_far_model.sv */
/* Far side: memory ready and an external bus master.
   Assumes start pulses for one cycle as each access is requested. */
`timescale 1ns/1ps
module ebpi_far_model (
    // Clock and commands
    input  wire logic       mclk,
    input  wire logic       start,
    input  wire logic [3:0] waits,
    input  wire logic       want_bus,
    // Pins
    output logic            ready_in,
    output logic            bus_release_req_in
);
    logic [4:0] cnt_q = 5'h00;
    always_ff @(posedge mclk) begin
        if (start) cnt_q <= {1'b0, waits} + 5'h01;
        else if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
    end
    assign ready_in           = (cnt_q == 5'h00);
    assign bus_release_req_in = want_bus;
endmodule : ebpi_far_model

/* File: sim/ebpi_top_tb_top.sv */
/* Self-checking bench for ebpi_top.
   Assumes the far model and the bound checker. */
`timescale 1ns/1ps
module ebpi_top_tb_top;
    import ebpi_pkg::*;
    logic mclk = 1'b0, nrst = 1'b0, eot_en = 1'b0, ch1 = 1'b0, ch2 = 1'b0, b;
    logic start = 1'b0, want = 1'b0, done, ready, breq, ack, soe, wloe, bclk, adoe;
    logic [3:0] waits = 4'h0;
    logic [NUM_PINS-1:0] pmode = '0, pout = PINS_ALL_ONE, pin;
    ebpi_width_type  width = EBPI_WIDTH_16;
    ebpi_req_type    req = '0;
    ebpi_strobe_type stb;
    ebpi_dram_type   d0, d1;
    int mismatches = 0, n_tests = 0, cyc = 0;
    ebpi_top #(.CLK_DIV(2)) dut (.mclk(mclk), .nrst(nrst), .bus_width(width),
        .port_mode(pmode), .dma_eot_enable(eot_en), .port_out(pout), .port_in_q(pin),
        .core_req(req), .core_done_q(done), .dma_eot_ch1(ch1), .dma_eot_ch2(ch2),
        .ready_in(ready), .bus_release_req_in(breq), .bus_release_ack_out(ack),
        .strobe_q(stb), .strobe_oe_q(soe), .write_strobe_lower_oe_q(wloe),
        .bus_clk_q(bclk), .dram_bank0_q(d0), .dram_bank1_q(d1), .addr_data_oe_q(adoe));
    ebpi_far_model far (.mclk(mclk), .start(start), .waits(waits), .want_bus(want),
        .ready_in(ready), .bus_release_req_in(breq));
    initial begin
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            mismatches++;
            close_out();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic close_out;
        if (mismatches == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step
    function automatic ebpi_strobe_type st(logic r, logic u, logic l, int a);
        return '{~r, ~u, ~l, ~(6'h01 << a)};
    endfunction : st
    // Expected DRAM pins of one bank on a 16-bit bus
    function automatic ebpi_dram_type dr(logic sel, logic wr, logic [1:0] ln);
        if (!sel) return '1;
        return '{1'b0, ~ln[0], ~ln[1], ~wr};
    endfunction : dr
    // One access; ready held low for w + 1 cycles by the far model
    task automatic access(input logic wr, input logic [1:0] ln, input logic [2:0] ar,
                          input logic [3:0] w, input ebpi_strobe_type exp);
        int n;
        req = '{1'b1, wr, ln, ar};
        waits = w;
        start = 1'b1;
        step(1);
        req.valid = 1'b0;
        start = 1'b0;
        step(1);
        check(stb, exp);
        check({d0, d1, adoe}, {dr(ar == 3'(DRAM_AREA0), wr, ln),
                               dr(ar == 3'(DRAM_AREA1), wr, ln), 1'b1});
        n = 0;
        while (done !== 1'b1 && n < 40) begin
            step(1);
            n++;
        end
        check(n, w + 1);
        step(1);
    endtask : access
    initial begin
        step(2);
        check(wloe, 1'b0);
        step(14);
        nrst = 1'b1;
        step(1);
        for (int a = 0; a < 4; a++) access(1'b0, 2'b11, a, a, st(1, 0, 0, a));
        access(1'b1, 2'b10, 3'h1, 4'h0, st(0, 1, 0, 1));
        access(1'b1, 2'b01, 3'h2, 4'h2, st(0, 0, 1, 2));
        access(1'b1, 2'b11, 3'h4, 4'h1, st(0, 1, 1, 4));
        access(1'b0, 2'b01, 3'h5, 4'h0, st(1, 0, 0, 5));
        width = EBPI_WIDTH_8;
        step(2);
        access(1'b1, 2'b11, 3'h0, 4'h1, st(0, 1, 0, 0));
        width = EBPI_WIDTH_16;
        want = 1'b1;
        step(6);
        check({ack, soe, adoe}, 3'b100);
        want = 1'b0;
        step(5);
        check(ack, 1'b0);
        eot_en = 1'b1;
        ch1 = 1'b1;
        ch2 = 1'b1;
        step(3);
        check({stb.area_sel_n[3], d1.row_n}, 2'b00);
        ch1 = 1'b0;
        ch2 = 1'b0;
        step(3);
        check({stb.area_sel_n[3], d1.row_n}, 2'b11);
        eot_en = 1'b0;
        pmode = PINS_ALL_ONE;
        pout = 18'h2A5A5;
        step(3);
        check({stb.area_sel_n[5:1], bclk}, {pout[PIN_CS5:PIN_CS1], pout[PIN_CLK]});
        check(pin[PIN_GRANT], 1'b1);
        pmode = '0;
        step(3);
        b = bclk;
        step(1);
        check(bclk, !b);
        close_out();
    end
endmodule : ebpi_top_tb_top
